//--- core/ecr_pkg.sv
// Purpose: Shared constants and carriers for the extended configuration register bank
// Assumes: 32-bit AXI4-Lite register access, 12-bit byte address
// Notes:   Offsets are byte addresses of aligned words
package ecr_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_LOG0        = 12'h13c;
  localparam logic [11:0] OFS_LOG1        = 12'h140;
  localparam logic [11:0] OFS_LOG2        = 12'h144;
  localparam logic [11:0] OFS_LOG3        = 12'h148;
  localparam logic [11:0] OFS_VC_HDR      = 12'h150;
  localparam logic [11:0] OFS_PORT_CAP1   = 12'h154;
  localparam logic [11:0] OFS_PORT_CAP2   = 12'h158;
  localparam logic [11:0] OFS_PORT_CTLSTS = 12'h15c;
  localparam logic [11:0] OFS_VC0_CAP     = 12'h160;
  localparam logic [11:0] OFS_VC0_CTL     = 12'h164;
  localparam logic [11:0] OFS_VC0_STS     = 12'h168;
  localparam logic [11:0] OFS_EXT_PIN     = 12'h300;
  localparam logic [11:0] OFS_EXTRA_PIN   = 12'h304;

  // Virtual-channel header fields
  localparam logic [15:0] VC_CAP_ID       = 16'h0002;
  localparam logic [3:0]  VC_CAP_VER      = 4'h1;
  localparam logic [11:0] VC_NEXT_PTR     = 12'h000;
  localparam logic [31:0] VC_HDR_WORD     = {VC_NEXT_PTR, VC_CAP_VER, VC_CAP_ID};
  localparam logic [31:0] PORT_CAP1_RST   = 32'h0000_0000;
  localparam logic [31:0] PORT_CAP2_RST   = 32'h0000_0000;
  localparam logic [31:0] PORT_CTLSTS_RST = 32'h0000_0000;
  localparam logic [31:0] VC0_CAP_RST     = 32'h0000_0000;
  localparam logic [31:0] VC0_STS_RST     = 32'h0000_0000;

  // Resource control: bit 0 and bit 31 fixed at one, bits 7:1 writable
  localparam logic [6:0]  TCVC_MAP_RST    = 7'h7f;
  localparam int          TCVC_LSB        = 1;
  localparam int          VC_EN_BIT       = 31;

  // Extended pin register field positions
  localparam int          EXT_CLR_LSB     = 0;
  localparam int          EXT_SET_LSB     = 3;
  localparam int          EXT_OECLR_LSB   = 6;
  localparam int          EXT_OESET_LSB   = 9;
  localparam int          EXT_IN_LSB      = 12;
  // Extra pin register field positions
  localparam int          GPO_CLR_LSB     = 0;
  localparam int          GPO_SET_LSB     = 4;
  localparam int          GPO_OECLR_LSB   = 8;
  localparam int          GPO_OESET_LSB   = 12;
  localparam int          GPI_IN_LSB      = 16;

  localparam logic [2:0]  EXT_RST         = 3'h0;
  localparam logic [3:0]  GPO_RST         = 4'h0;
  localparam logic [127:0] LOG_RST        = 128'h0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // One secondary-bus transaction as seen by the error detector
  typedef struct packed {
    logic        dac;
    logic [3:0]  attr_cbe;
    logic [31:0] attr_ad;
    logic [3:0]  cmd_lo;
    logic [3:0]  cmd_hi;
    logic [31:0] addr_lo;
    logic [31:0] addr_hi;
  } ecr_capture_t;

  // Pin drive state
  typedef struct packed {
    logic [2:0] ext_out;
    logic [2:0] ext_oe;
    logic [3:0] gpo_out;
    logic [3:0] gpo_oe;
  } ecr_pins_t;

endpackage

//--- core/ecr_regs.sv
// Purpose: Extended configuration register bank: transaction log, VC structure, pin registers
// Assumes: AXI4-Lite slave, one write and one read outstanding, synchronous inputs
// Notes:   Log is sticky and cleared only by the power-on reset
// How it works
// RQ1 - On capture, log bits 35:0 take the attribute-phase byte enables and address/data lines.
// RQ2 - On capture, log bits 39:36 take the byte enables of the first address phase.
// RQ3 - On capture of a dual-address transaction, log bits 43:40 take the second-phase byte enables.
// RQ4 - On capture, log bits 95:64 take the first-phase address.
// RQ5 - On capture of a dual-address transaction, log bits 127:96 take the second-phase address.
// RQ6 - The VC header reads id 0002h, version 1h and a zero next pointer.
// RQ7 - Ones written to extended bits 2:0 drive the matching output values of pins 6 to 4 low.
// RQ8 - Ones written to extended bits 5:3 drive the matching output values high.
// RQ9 - Ones written to extended bits 8:6 clear the matching output enables.
// RQ10 - Ones written to extended bits 11:9 set the matching output enables.
// RQ11 - Ones written to extra bits 3:0 clear the matching extra outputs.
// RQ12 - Ones written to extra bits 7:4 set the matching extra outputs.
// RQ13 - Ones written to extra bits 11:8 clear the matching extra output enables.
// RQ14 - Ones written to extra bits 15:12 set the matching extra output enables.
// RQ15 - Extra bits 19:16 and extended bits 14:12 read the sampled input pin levels.
// RQ16 - Set and clear fields read the current state, and a pin drives only while enabled.
// RQ17 - The log loads only on a captured error, survives normal reset and clears on power-on reset.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ecr_regs (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  por_n,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  err_capture,
  input  wire ecr_pkg::ecr_capture_t err_txn,
  input  wire logic [2:0]            ext_pin_in,
  input  wire logic [3:0]            gpi_in,
  output ecr_pkg::ecr_pins_t         pins
);
  import ecr_pkg::*;

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    is_mapped = (w == OFS_LOG0) || (w == OFS_LOG1) || (w == OFS_LOG2) || (w == OFS_LOG3) ||
                (w == OFS_VC_HDR) || (w == OFS_PORT_CAP1) || (w == OFS_PORT_CAP2) ||
                (w == OFS_PORT_CTLSTS) || (w == OFS_VC0_CAP) || (w == OFS_VC0_CTL) ||
                (w == OFS_VC0_STS) || (w == OFS_EXT_PIN) || (w == OFS_EXTRA_PIN);
  endfunction

  logic [11:0]  aw_addr_reg;
  logic         aw_held_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         w_held_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;
  logic [127:0] log_reg;
  logic [127:0] log_next;
  logic [6:0]   tcvc_reg;
  logic [6:0]   tcvc_next;
  logic [2:0]   ext_out_reg;
  logic [2:0]   ext_out_next;
  logic [2:0]   ext_oe_reg;
  logic [2:0]   ext_oe_next;
  logic [3:0]   gpo_reg;
  logic [3:0]   gpo_next;
  logic [3:0]   gpo_oe_reg;
  logic [3:0]   gpo_oe_next;
  logic [2:0]   ext_smp_reg;
  logic [3:0]   gpi_smp_reg;

  // Write path decode
  wire          wr_do     = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [11:0]   wr_word   = {aw_addr_reg[11:2], 2'b00};
  wire [31:0]   wr_mask   = strb_mask(w_strb_reg);
  wire [31:0]   wr_bits   = w_data_reg & wr_mask;
  wire          wr_ext    = wr_do && (wr_word == OFS_EXT_PIN);
  wire          wr_extra  = wr_do && (wr_word == OFS_EXTRA_PIN);
  wire          wr_vc0    = wr_do && (wr_word == OFS_VC0_CTL);
  wire          rd_take   = s_axi_arvalid && s_axi_arready;
  wire [11:0]   rd_word   = {s_axi_araddr[11:2], 2'b00};

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Set wins when one write both sets and clears a bit
  assign ext_out_next = wr_ext ? ((ext_out_reg & ~wr_bits[EXT_CLR_LSB +: 3])              // RQ7
                                  | wr_bits[EXT_SET_LSB +: 3]) : ext_out_reg;               // RQ8
  assign ext_oe_next  = wr_ext ? ((ext_oe_reg & ~wr_bits[EXT_OECLR_LSB +: 3])             // RQ9
                                  | wr_bits[EXT_OESET_LSB +: 3]) : ext_oe_reg;              // RQ10
  assign gpo_next     = wr_extra ? ((gpo_reg & ~wr_bits[GPO_CLR_LSB +: 4])                // RQ11
                                    | wr_bits[GPO_SET_LSB +: 4]) : gpo_reg;                 // RQ12
  assign gpo_oe_next  = wr_extra ? ((gpo_oe_reg & ~wr_bits[GPO_OECLR_LSB +: 4])           // RQ13
                                    | wr_bits[GPO_OESET_LSB +: 4]) : gpo_oe_reg;            // RQ14
  // Byte lanes left out of the strobe keep the old map bits
  assign tcvc_next    = wr_vc0 ? ((tcvc_reg & ~wr_mask[TCVC_LSB +: 7])
                                  | wr_bits[TCVC_LSB +: 7]) : tcvc_reg;

  // Second-phase fields hold zero for single-address transactions
  assign log_next = err_capture ? {                                                         // RQ17
                      (err_txn.dac ? err_txn.addr_hi : 32'h0000_0000),                      // RQ5
                      err_txn.addr_lo,                                                      // RQ4
                      20'h0_0000,
                      (err_txn.dac ? err_txn.cmd_hi : 4'h0),                                // RQ3
                      err_txn.cmd_lo,                                                       // RQ2
                      err_txn.attr_cbe, err_txn.attr_ad}                                    // RQ1
                    : log_reg;

  // Read data selection
  wire [31:0] ext_word   = {17'h0_0000, ext_smp_reg, ext_oe_reg, ext_oe_reg,               // RQ15
                            ext_out_reg, ext_out_reg};                                      // RQ16
  wire [31:0] extra_word = {12'h000, gpi_smp_reg, gpo_oe_reg, gpo_oe_reg, gpo_reg, gpo_reg}; // RQ16
  wire [31:0] vc0_word   = {1'b1, 23'h00_0000, tcvc_reg, 1'b1};
  wire [31:0] rd_sel     =
    (rd_word == OFS_LOG0)        ? log_reg[31:0]   :
    (rd_word == OFS_LOG1)        ? log_reg[63:32]  :
    (rd_word == OFS_LOG2)        ? log_reg[95:64]  :
    (rd_word == OFS_LOG3)        ? log_reg[127:96] :
    (rd_word == OFS_VC_HDR)      ? VC_HDR_WORD     :                                        // RQ6
    (rd_word == OFS_PORT_CAP1)   ? PORT_CAP1_RST   :
    (rd_word == OFS_PORT_CAP2)   ? PORT_CAP2_RST   :
    (rd_word == OFS_PORT_CTLSTS) ? PORT_CTLSTS_RST :
    (rd_word == OFS_VC0_CAP)     ? VC0_CAP_RST     :
    (rd_word == OFS_VC0_CTL)     ? vc0_word        :
    (rd_word == OFS_VC0_STS)     ? VC0_STS_RST     :
    (rd_word == OFS_EXT_PIN)     ? ext_word        :
    (rd_word == OFS_EXTRA_PIN)   ? extra_word      : 32'h0000_0000;

  // Pins drive only while enabled; value and enable both from flops
  assign pins = '{ext_out: ext_out_reg, ext_oe: ext_oe_reg,                                 // RQ16
                  gpo_out: gpo_reg, gpo_oe: gpo_oe_reg};

  // Write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response and read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_sel;
        rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Pin state and input sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_out_reg <= EXT_RST;
      ext_oe_reg  <= EXT_RST;
      gpo_reg     <= GPO_RST;
      gpo_oe_reg  <= GPO_RST;
      tcvc_reg    <= TCVC_MAP_RST;
      ext_smp_reg <= EXT_RST;
      gpi_smp_reg <= GPO_RST;
    end else begin
      ext_out_reg <= ext_out_next;
      ext_oe_reg  <= ext_oe_next;
      gpo_reg     <= gpo_next;
      gpo_oe_reg  <= gpo_oe_next;
      tcvc_reg    <= tcvc_next;
      ext_smp_reg <= ext_pin_in;                                                            // RQ15
      gpi_smp_reg <= gpi_in;                                                                // RQ15
    end
  end

  // Sticky log: ordinary reset leaves it alone so software can read it after recovery
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      log_reg <= LOG_RST;                                                                   // RQ17
    end else begin
      log_reg <= log_next;
    end
  end

  chk_log_attr_low: assert property (@(posedge aclk) disable iff (!por_n) // RQ1
    err_capture |=> log_reg[35:0] == {$past(err_txn.attr_cbe), $past(err_txn.attr_ad)})
    else $error("Log attribute field wrong after capture");

  chk_log_cmd_lo: assert property (@(posedge aclk) disable iff (!por_n) // RQ2
    err_capture |=> log_reg[39:36] == $past(err_txn.cmd_lo))
    else $error("Log first command field wrong");

  chk_log_cmd_hi: assert property (@(posedge aclk) disable iff (!por_n) // RQ3
    (err_capture && err_txn.dac) |=> log_reg[43:40] == $past(err_txn.cmd_hi))
    else $error("Log second command field wrong");

  chk_log_addr_lo: assert property (@(posedge aclk) disable iff (!por_n) // RQ4
    err_capture |=> log_reg[95:64] == $past(err_txn.addr_lo))
    else $error("Log first address wrong");

  chk_log_addr_hi: assert property (@(posedge aclk) disable iff (!por_n) // RQ5
    (err_capture && err_txn.dac) |=> log_reg[127:96] == $past(err_txn.addr_hi))
    else $error("Log upper address wrong");

  chk_vc_header_read: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    (rd_take && rd_word == OFS_VC_HDR) |=> s_axi_rvalid && s_axi_rdata == 32'h0001_0002)
    else $error("VC header read value wrong");

  chk_ext_out_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    (wr_ext && wr_bits[0] && !wr_bits[3]) |=> !pins.ext_out[0])
    else $error("Extended pin not cleared");

  chk_ext_out_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    (wr_ext && wr_bits[5]) |=> pins.ext_out[2])
    else $error("Extended pin not set");

  chk_ext_oe_ctl: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
    (wr_ext && wr_bits[7] && !wr_bits[10]) |=> !pins.ext_oe[1])
    else $error("Extended enable not cleared");

  chk_ext_oe_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    (wr_ext && wr_bits[11]) |=> pins.ext_oe[2])
    else $error("Extended enable not set");

  chk_gpo_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
    (wr_extra && wr_bits[3] && !wr_bits[7]) |=> !pins.gpo_out[3])
    else $error("Extra output not cleared");

  chk_gpo_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    (wr_extra && wr_bits[4]) |=> pins.gpo_out[0])
    else $error("Extra output not set");

  chk_gpo_oe_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    (wr_extra && wr_bits[9] && !wr_bits[13]) |=> !pins.gpo_oe[1])
    else $error("Extra enable not cleared");

  chk_gpo_oe_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (wr_extra && wr_bits[14]) |=> pins.gpo_oe[2])
    else $error("Extra enable not set");

  chk_gpi_readback: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
    (rd_take && rd_word == OFS_EXTRA_PIN) |=> s_axi_rdata[19:16] == $past(gpi_smp_reg))
    else $error("Extra input readback wrong");

  chk_pins_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
    (!wr_do) |=> $stable(pins))
    else $error("Pin state changed without a write");

  chk_log_sticky: assert property (@(posedge aclk) disable iff (!por_n) // RQ17
    (!err_capture) |=> $stable(log_reg))
    else $error("Log changed without a capture");

endmodule
`default_nettype wire

//--- verification/ecr_pin_model.sv
// Purpose: Far side of the pin registers, outside drivers on extended and extra input pins
// Assumes: Block drives an extended pin only while its enable is one
// Notes:   Extra inputs are separate pins, never looped back from the outputs
`timescale 1ns/100ps
`default_nettype none
module ecr_pin_model (
  input  wire ecr_pkg::ecr_pins_t pins,
  input  wire logic [2:0]         ext_far,
  input  wire logic [3:0]         gpi_far,
  output logic [2:0]              ext_lvl,
  output logic [3:0]              gpi_lvl
);
  import ecr_pkg::*;
  // Undriven pin follows the outside level, so a stuck enable shows up in readback
  assign ext_lvl = (pins.ext_oe & pins.ext_out) | (~pins.ext_oe & ext_far);
  assign gpi_lvl = gpi_far;
endmodule
`default_nettype wire

//--- verification/ecr_regs_bench.sv
// Purpose: Self-checking bench for the extended configuration register bank
// Assumes: AXI4-Lite master with one write and one read at a time
// Notes:   Random pin traffic with fixed seed, log capture across both resets
`timescale 1ns/100ps
`default_nettype none
module ecr_regs_bench;
  import ecr_pkg::*;
  logic         aclk, aresetn, por_n, err_capture;
  logic [11:0]  awaddr, araddr, a;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [31:0]  wdata, rdata, d, m;
  logic [3:0]   wstrb, gpi_in, gpi_far, s;
  logic [1:0]   bresp, rresp;
  logic [2:0]   ext_pin_in, ext_far;
  logic [127:0] tmp, lexp;
  ecr_capture_t err_txn;
  ecr_pins_t    pins, pexp;
  integer       seed, failures, total_checks, cycles;
  logic [11:0]  zr [9] = '{OFS_PORT_CAP1, OFS_PORT_CAP2, OFS_PORT_CTLSTS, OFS_VC0_CAP, OFS_VC0_STS,
                         OFS_LOG0, OFS_LOG1, OFS_LOG2, OFS_LOG3};

  ecr_regs dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .err_capture(err_capture), .err_txn(err_txn), .ext_pin_in(ext_pin_in), .gpi_in(gpi_in), .pins(pins));
  ecr_pin_model far (.pins(pins), .ext_far(ext_far), .gpi_far(gpi_far), .ext_lvl(ext_pin_in), .gpi_lvl(gpi_in));

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  function automatic logic [127:0] log_of(ecr_capture_t t);
    return {t.dac ? t.addr_hi : 32'h0, t.addr_lo, 20'h0, t.dac ? t.cmd_hi : 4'h0, t.cmd_lo, t.attr_cbe, t.attr_ad};
  endfunction
  // Set beats clear when one write hits both
  function automatic ecr_pins_t pin_next(ecr_pins_t p, logic [11:0] ad, logic [31:0] dv);
    ecr_pins_t n;
    n = p;
    if (ad == OFS_EXT_PIN) begin
      n.ext_out = (p.ext_out & ~dv[2:0]) | dv[5:3];
      n.ext_oe  = (p.ext_oe & ~dv[8:6]) | dv[11:9];
    end else if (ad == OFS_EXTRA_PIN) begin
      n.gpo_out = (p.gpo_out & ~dv[3:0]) | dv[7:4];
      n.gpo_oe  = (p.gpo_oe & ~dv[11:8]) | dv[15:12];
    end
    return n;
  endfunction
  function automatic logic [31:0] ext_rb(ecr_pins_t p, logic [2:0] f);
    return {17'h0, (p.ext_oe & p.ext_out) | (~p.ext_oe & f), p.ext_oe, p.ext_oe, p.ext_out, p.ext_out};
  endfunction
  function automatic logic [31:0] extra_rb(ecr_pins_t p, logic [3:0] g);
    return {12'h0, g, p.gpo_oe, p.gpo_oe, p.gpo_out, p.gpo_out};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] dv, input logic [3:0] st, input logic [1:0] re);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dv;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk($sformatf("bresp %h", ad), {30'h0, bresp}, {30'h0, re});
    bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp, input logic [1:0] re);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    chk($sformatf("rdata %h", ad), rdata, exp);
    chk($sformatf("rresp %h", ad), {30'h0, rresp}, {30'h0, re});
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic por);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n <= !por;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Run is well under a thousand cycles, so this only trips on a hang
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_sim;
    end
  end

  initial begin
    seed = 32'h6a48;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    {aresetn, por_n, err_capture, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_txn = '0;
    ext_far = 3'h5;
    gpi_far = 4'ha;
    do_reset(1'b1);
    rd_chk(OFS_VC_HDR, 32'h0001_0002, RESP_OKAY);
    foreach (zr[i]) rd_chk(zr[i], 32'h0, RESP_OKAY);
    rd_chk(OFS_VC0_CTL, 32'h8000_00ff, RESP_OKAY);
    wr(OFS_VC0_CTL, 32'h0, 4'hf, RESP_OKAY);
    rd_chk(OFS_VC0_CTL, 32'h8000_0001, RESP_OKAY);
    wr(OFS_VC0_CTL, 32'h0000_00aa, 4'h0, RESP_OKAY);
    rd_chk(OFS_VC0_CTL, 32'h8000_0001, RESP_OKAY);
    wr(OFS_VC_HDR, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd_chk(OFS_VC_HDR, 32'h0001_0002, RESP_OKAY);
    rd_chk(12'h14c, 32'h0, RESP_SLVERR);
    pexp = '0;
    for (int i = 0; i < 60; i++) begin
      a = i[0] ? OFS_EXTRA_PIN : OFS_EXT_PIN;
      d = (i < 2) ? 32'hffff_ffff : (i == 2) ? 32'h0000_01c7 : (i == 3) ? 32'h0000_0f0f : (i == 4) ? 32'h0 : $random(seed);
      s = (i < 6) ? 4'hf : 4'($random(seed));
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      ext_far <= 3'($random(seed));
      gpi_far <= 4'($random(seed));
      wr(a, d, s, RESP_OKAY);
      pexp = pin_next(pexp, a, d & m);
      chk("pins", {18'h0, pins}, {18'h0, pexp});
      rd_chk(OFS_EXT_PIN, ext_rb(pexp, ext_far), RESP_OKAY);
      rd_chk(OFS_EXTRA_PIN, extra_rb(pexp, gpi_far), RESP_OKAY);
    end
    wr(12'h14c, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    chk("pins unmapped", {18'h0, pins}, {18'h0, pexp});
    for (int k = 0; k < 2; k++) begin
      tmp = {$random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge aclk);
      err_txn <= {k[0], tmp[107:0]};
      err_capture <= 1'b1;
      lexp = log_of({k[0], tmp[107:0]});
      @(posedge aclk);
      err_capture <= 1'b0;
      err_txn <= ~err_txn;
      for (int j = 0; j < 4; j++) rd_chk(OFS_LOG0 + 12'(4 * j), lexp[32 * j +: 32], RESP_OKAY);
    end
    do_reset(1'b0);
    chk("pins after reset", {18'h0, pins}, 32'h0);
    for (int j = 0; j < 4; j++) rd_chk(OFS_LOG0 + 12'(4 * j), lexp[32 * j +: 32], RESP_OKAY);
    do_reset(1'b1);
    for (int j = 0; j < 4; j++) rd_chk(OFS_LOG0 + 12'(4 * j), 32'h0, RESP_OKAY);
    end_sim;
  end
endmodule
`default_nettype wire
